/* File: hdl/bridge_leg_deadtime.sv */
// One half-bridge leg with break-before-make dead time insertion.
`timescale 1ns/1ns
`default_nettype none
module bridge_leg_deadtime
  import hbridge_pkg::*;
(
  input wire logic core_clk, // Core clock.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic clk_en, // Clock enable, freezes state when low.
  input wire logic want_high, // Requested high-side switch state.
  input wire logic want_low, // Requested low-side switch state.
  output logic high_on, // Applied high-side switch state.
  output logic low_on // Applied low-side switch state.
);
  import hbridge_pkg::*;

  logic [CNT_W-1:0] dead_reg; // Remaining dead-time cycles.
  logic changed; // Request differs from what is applied.
  logic dead_done; // Dead time has run out.

  // A change is pending whenever the applied pair differs from the request.
  assign changed = (want_high != high_on) || (want_low != low_on);
  assign dead_done = (dead_reg == '0);

  // On any change both switches open, and the new pair is applied after the dead time, at once for the first pair after reset.
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      high_on <= 1'b0;
      low_on <= 1'b0;
      dead_reg <= '0;
    end
    else if (clk_en)
    begin
      if (changed && (high_on || low_on))
      begin
        // Open the leg first and start the dead time.
        high_on <= 1'b0; // see R14
        low_on <= 1'b0;
        dead_reg <= CNT_W'(DEAD_CYC); // see R14
      end
      else if (changed && !dead_done)
      begin
        // Leg is open; count the dead time down.
        dead_reg <= dead_reg - 1'b1; // see R14
      end
      else if (changed)
      begin
        // Dead time spent; the pair never closes both switches together.
        high_on <= want_high && !want_low;
        low_on <= want_low;
        dead_reg <= CNT_W'(DEAD_CYC);
      end
    end
  end
endmodule
`default_nettype wire

/* File: hdl/hbridge_fault_standby_control.sv */
// Control logic of one H-bridge: chopping, dead time, standby sequence and fault handling.
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// R01: Fault turns on pull-down, flag reads low.
// R02: Normal status keeps the pull-down off.
// R03: Host leaves shared pin on pull-up only.
// R04: Fault clears only by supply or standby.
// R05: Thermal trip: fast decay, then off.
// R06: High-side over-current: low slow, off after 80ms.
// R07: Low-side over-current: discharge by high slow decay.
// R08: Standby input low standby, high normal.
// R09: Standby 100us after zero, forced by 1ms.
// R10: Standby discards all control state.
// R11: Forward switch sets for charge, slow, fast.
// R12: Reverse switch sets for charge, slow, fast.
// R13: Current regulated by automatic phase switching.
// R14: Dead time on every switch transition.
// R15: Chopping rate derived from the oscillator.
// R16: Chopping period is oscillator divided by 16.
// R17: Mode latched from shared pin at release.
// R18: Over-current pulses under 1.2us are ignored.
module hbridge_fault_standby_control
  import hbridge_pkg::*;
#(
  parameter int HEAT_MAX = HEAT_MAX_CYC, // Thermal discharge limit in cycles.
  parameter int OC_DIS = OC_DIS_CYC, // Over-current discharge time in cycles.
  parameter int SLEEP_ZERO = SLEEP_ZERO_CYC, // Standby delay after zero current in cycles.
  parameter int SLEEP_MAX = SLEEP_MAX_CYC // Forced standby limit in cycles.
)
(
  input wire logic core_clk, // Oscillator clock.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic clk_en, // Clock enable, freezes all state when low.
  input wire logic standby_n, // Standby pin, low requests standby.
  input wire logic mode_fault_in, // Level seen on the shared mode and fault pin.
  input wire logic in1, // Input 1 in IN mode, phase in phase mode.
  input wire logic in2, // Input 2 in IN mode, enable in phase mode.
  input wire logic supply_ok, // Motor supply present, low while it is lost.
  input wire logic thermal_trip, // Thermal comparator output.
  input wire logic overcurrent_trip, // Over-current comparator output.
  input wire logic oc_on_high, // Over-current was seen on a high-side switch.
  input wire logic limit_hit, // Motor current reached the set threshold.
  input wire logic current_zero, // Motor current detected as zero.
  output logic high_sw_1, // High-side switch of leg 1.
  output logic high_sw_2, // High-side switch of leg 2.
  output logic low_sw_1, // Low-side switch of leg 1.
  output logic low_sw_2, // Low-side switch of leg 2.
  output logic fault_pin_out, // Output level of the shared pin, always low.
  output logic fault_pin_oe, // Pull-down enable of the shared pin.
  output logic phase_mode, // Latched control mode, high for phase mode.
  output logic standby_active // Device is in standby.
);
  import hbridge_pkg::*;

  logic [7:0] sync1_reg; // First synchroniser stage of the pins.
  logic [7:0] sync2_reg; // Second synchroniser stage of the pins.
  logic s_standby_n; // Synchronised standby input.
  logic s_mode; // Synchronised shared pin level.
  logic s_in1; // Synchronised input 1.
  logic s_in2; // Synchronised input 2.
  logic s_supply; // Synchronised supply status.
  logic s_thermal; // Synchronised thermal trip.
  logic s_oc; // Synchronised over-current trip.
  logic s_limit; // Synchronised threshold hit.
  logic s_zero_raw; // Synchronised zero-current level.
  logic oc_side_s1_reg; // First stage for the over-current side.
  logic oc_side_reg; // Synchronised over-current side.
  logic zero_s1_reg; // First stage for zero-current detection.
  ctrl_state_e state_reg; // Sequencing state.
  ctrl_state_e state_next; // Next sequencing state.
  chop_phase_e phase_reg; // Chopping phase.
  chop_phase_e phase_next; // Next chopping phase.
  logic [TMR_W-1:0] tmr_reg; // Long timer for discharge and standby.
  logic [TMR_W-1:0] zero_tmr_reg; // Time since current went to zero.
  logic [3:0] chop_cnt_reg; // Position inside the chopping period.
  logic [CNT_W-1:0] fast_cnt_reg; // Cycles of fast decay spent.
  logic [CNT_W-1:0] oc_band_reg; // Cycles the over-current trip has held.
  logic fault_reg; // Latched fault indication.
  logic oc_high_reg; // Over-current was on the high side.
  logic standby_prev_reg; // Standby input one cycle ago.
  logic oc_event; // Filtered over-current event.
  logic chop_start; // Last cycle of a chopping period.
  logic fwd; // Forward current direction.
  logic drive; // Bridge is to be driven.
  logic brake; // Short brake request in IN mode.
  logic want_h1, want_h2, want_l1, want_l2; // Switch requests into the legs.
  logic run_h1, run_h2, run_l1, run_l2; // Switch pattern of the running bridge.
  logic fault_clear; // Supply loss or standby clears the fault.

  // Pins cross into the clock domain through two flip-flops.
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      sync1_reg <= 8'h00;
      sync2_reg <= 8'h00;
      oc_side_s1_reg <= 1'b0;
      oc_side_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      sync1_reg <= {standby_n, mode_fault_in, in1, in2, supply_ok, thermal_trip,
                    overcurrent_trip, limit_hit};
      sync2_reg <= sync1_reg;
      oc_side_s1_reg <= oc_on_high;
      oc_side_reg <= oc_side_s1_reg;
    end
  end

  // Zero-current level gets its own pair of stages.
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      zero_s1_reg <= 1'b0;
      s_zero_raw <= 1'b0;
    end
    else if (clk_en)
    begin
      zero_s1_reg <= current_zero;
      s_zero_raw <= zero_s1_reg;
    end
  end

  assign s_standby_n = sync2_reg[7];
  assign s_mode = sync2_reg[6];
  assign s_in1 = sync2_reg[5];
  assign s_in2 = sync2_reg[4];
  assign s_supply = sync2_reg[3];
  assign s_thermal = sync2_reg[2];
  assign s_oc = sync2_reg[1];
  assign s_limit = sync2_reg[0];

  // Input decode: phase mode uses in1 as direction and in2 as enable.
  assign fwd = phase_mode ? s_in1 : (s_in1 && !s_in2);
  assign brake = !phase_mode && s_in1 && s_in2;
  assign drive = phase_mode ? s_in2 : (s_in1 ^ s_in2);
  assign oc_event = (oc_band_reg >= CNT_W'(OC_BAND_CYC)); // see R18
  assign chop_start = (chop_cnt_reg == 4'(CHOP_DIV - 1)); // see R15
  // Clearing on the entry into standby drops the flag one cycle after standby is shown.
  assign fault_clear = !s_supply || (state_next == ST_STANDBY); // see R04

  // Running pattern per phase and direction; brake holds both low switches.
  assign run_h1 = drive && ((phase_reg == PH_CHARGE) ? fwd : (phase_reg == PH_FAST) && !fwd); // see R11
  assign run_h2 = drive && ((phase_reg == PH_CHARGE) ? !fwd : (phase_reg == PH_FAST) && fwd); // see R12
  assign run_l1 = brake || (drive && ((phase_reg == PH_CHARGE) ? !fwd : (phase_reg != PH_FAST) || fwd)); // see R11
  assign run_l2 = brake || (drive && ((phase_reg == PH_CHARGE) ? fwd : (phase_reg != PH_FAST) || !fwd)); // see R12

  // Leg requests by state: discharge patterns for faults, slow decay while waiting.
  assign want_h1 = (state_reg == ST_RUN) ? run_h1 :
                   (state_reg == ST_HEAT_DIS) ? !fwd : // see R05
                   (state_reg == ST_OC_DIS) && !oc_high_reg; // see R07
  assign want_h2 = (state_reg == ST_RUN) ? run_h2 :
                   (state_reg == ST_HEAT_DIS) ? fwd :
                   (state_reg == ST_OC_DIS) && !oc_high_reg;
  assign want_l1 = (state_reg == ST_RUN) ? run_l1 :
                   (state_reg == ST_HEAT_DIS) ? fwd :
                   ((state_reg == ST_OC_DIS) && oc_high_reg) || (state_reg == ST_SLEEP_WAIT); // see R06
  assign want_l2 = (state_reg == ST_RUN) ? run_l2 :
                   (state_reg == ST_HEAT_DIS) ? !fwd :
                   ((state_reg == ST_OC_DIS) && oc_high_reg) || (state_reg == ST_SLEEP_WAIT);

  // Sequencing: standby has priority, then thermal, then over-current.
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_STANDBY:
        if (s_standby_n) state_next = ST_RUN; // see R08
      ST_RUN:
        if (!s_standby_n) state_next = ST_SLEEP_WAIT; // see R08
        else if (s_thermal) state_next = ST_HEAT_DIS;
        else if (oc_event) state_next = ST_OC_DIS;
      ST_SLEEP_WAIT:
        if (zero_tmr_reg >= TMR_W'(SLEEP_ZERO) || tmr_reg >= TMR_W'(SLEEP_MAX))
          state_next = ST_STANDBY; // see R09
      ST_HEAT_DIS:
        if (!s_standby_n) state_next = ST_SLEEP_WAIT;
        else if (s_zero_raw || tmr_reg >= TMR_W'(HEAT_MAX)) state_next = ST_HIZ; // see R05
      ST_OC_DIS:
        if (!s_standby_n) state_next = ST_SLEEP_WAIT;
        else if (tmr_reg >= TMR_W'(OC_DIS)) state_next = ST_HIZ; // see R06
      ST_HIZ:
        if (!s_standby_n) state_next = ST_SLEEP_WAIT;
      default:
        state_next = ST_STANDBY;
    endcase
  end

  // Chopping phase: charge to threshold, fixed fast share, slow to period end.
  always_comb
  begin
    phase_next = phase_reg;
    case (phase_reg)
      PH_CHARGE:
        if (s_limit) phase_next = PH_FAST; // see R13
      PH_FAST:
        if (fast_cnt_reg >= CNT_W'(FAST_CYC - 1)) phase_next = PH_SLOW; // see R13
      PH_SLOW:
        if (chop_start) phase_next = PH_CHARGE; // see R13
      default:
        phase_next = PH_CHARGE;
    endcase
  end

  // State, timers and phase; the long timer restarts on every state change.
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      state_reg <= ST_STANDBY;
      phase_reg <= PH_CHARGE;
      tmr_reg <= '0;
      zero_tmr_reg <= '0;
      chop_cnt_reg <= 4'h0;
      fast_cnt_reg <= '0;
    end
    else if (clk_en)
    begin
      state_reg <= state_next;
      tmr_reg <= (state_next != state_reg) ? '0 : tmr_reg + 1'b1;
      zero_tmr_reg <= (s_zero_raw && state_reg == ST_SLEEP_WAIT) ? zero_tmr_reg + 1'b1 : '0;
      chop_cnt_reg <= (state_reg == ST_RUN) ? chop_cnt_reg + 1'b1 : 4'h0; // see R16
      phase_reg <= (state_reg == ST_RUN) ? phase_next : PH_CHARGE; // see R10
      fast_cnt_reg <= (phase_reg == PH_FAST) ? fast_cnt_reg + 1'b1 : '0;
    end
  end

  // Over-current dead band: the trip must hold without a break.
  always_ff @(posedge core_clk)
  begin
    if (rst)
      oc_band_reg <= '0;
    else if (clk_en)
    begin
      if (!s_oc)
        oc_band_reg <= '0; // see R18
      else if (!oc_event)
        oc_band_reg <= oc_band_reg + 1'b1;
    end
  end

  // Fault latch; a new fault wins over a clear in the same cycle.
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      fault_reg <= 1'b0;
      oc_high_reg <= 1'b0;
      fault_pin_oe <= 1'b0;
      fault_pin_out <= 1'b0;
    end
    else if (clk_en)
    begin
      if (state_reg == ST_RUN && s_standby_n && (s_thermal || oc_event))
      begin
        fault_reg <= 1'b1; // see R01
        oc_high_reg <= oc_side_reg;
      end
      else if (fault_clear)
        fault_reg <= 1'b0; // see R04
      fault_pin_oe <= fault_reg; // see R01, see R02, see R03
      fault_pin_out <= 1'b0;
    end
  end

  // Control mode is caught on the release of standby and dropped in standby.
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      phase_mode <= 1'b0;
      standby_prev_reg <= 1'b0;
      standby_active <= 1'b1;
    end
    else if (clk_en)
    begin
      standby_prev_reg <= s_standby_n;
      if (s_standby_n && !standby_prev_reg)
        phase_mode <= s_mode; // see R17
      else if (state_reg == ST_STANDBY)
        phase_mode <= 1'b0; // see R10
      standby_active <= (state_next == ST_STANDBY);
    end
  end

  // Leg 1 carries high_sw_1 and low_sw_1.
  bridge_leg_deadtime leg1 (
    .core_clk(core_clk),
    .rst(rst),
    .clk_en(clk_en),
    .want_high(want_h1),
    .want_low(want_l1),
    .high_on(high_sw_1),
    .low_on(low_sw_1)
  );

  // Leg 2 carries high_sw_2 and low_sw_2.
  bridge_leg_deadtime leg2 (
    .core_clk(core_clk),
    .rst(rst),
    .clk_en(clk_en),
    .want_high(want_h2),
    .want_low(want_l2),
    .high_on(high_sw_2),
    .low_on(low_sw_2)
  );
endmodule
`default_nettype wire

/* File: hdl/hbridge_pkg.sv */
// Package with the timing constants and state encodings of the H-bridge control block.
package hbridge_pkg;
  // Core clock rate in kHz.
  localparam int CLK_KHZ = 50000;
  // Dead time in ns; a least time, so it rounds up.
  localparam int DEAD_NS = 100;
  localparam int DEAD_CYC = (DEAD_NS * CLK_KHZ + 999999) / 1000000;
  // Over-current dead band in ns; a least time, so it rounds up.
  localparam int OC_BAND_NS = 1200;
  localparam int OC_BAND_CYC = (OC_BAND_NS * CLK_KHZ + 999999) / 1000000;
  // Thermal discharge limit in us; a longest time, so it rounds down.
  localparam int HEAT_MAX_US = 1000;
  localparam int HEAT_MAX_CYC = HEAT_MAX_US * CLK_KHZ / 1000;
  // Over-current discharge time in ms.
  localparam int OC_DIS_MS = 80;
  localparam int OC_DIS_CYC = OC_DIS_MS * CLK_KHZ;
  // Standby delay after zero current in us; a least time, rounds up.
  localparam int SLEEP_ZERO_US = 100;
  localparam int SLEEP_ZERO_CYC = (SLEEP_ZERO_US * CLK_KHZ + 999) / 1000;
  // Forced standby limit in us; a longest time, rounds down.
  localparam int SLEEP_MAX_US = 1000;
  localparam int SLEEP_MAX_CYC = SLEEP_MAX_US * CLK_KHZ / 1000;
  // Oscillator to chopping period divide ratio.
  localparam int CHOP_DIV = 16;
  // Fast-decay share of the chopping period, 37.5 percent of 16.
  localparam int FAST_CYC = 6;
  // Width of the long timer.
  localparam int TMR_W = 23;
  // Width of the short counters.
  localparam int CNT_W = 8;

  // Top-level sequencing states, one-hot.
  typedef enum logic [5:0] {
    ST_STANDBY = 6'h01,
    ST_RUN = 6'h02,
    ST_SLEEP_WAIT = 6'h04,
    ST_HEAT_DIS = 6'h08,
    ST_OC_DIS = 6'h10,
    ST_HIZ = 6'h20
  } ctrl_state_e;

  // Chopping phases inside a running bridge, one-hot.
  typedef enum logic [2:0] {
    PH_CHARGE = 3'h1,
    PH_FAST = 3'h2,
    PH_SLOW = 3'h4
  } chop_phase_e;
endpackage

/* File: tb/hbridge_fault_standby_control_assertions.sv */
// Checker of the H-bridge control block, bound to its top module.
`timescale 1ns/1ns
`default_nettype none
module hbridge_fault_standby_control_assertions
#(
  parameter int OC_DIS = 300, // Over-current discharge time in cycles.
  parameter int SLEEP_MAX = 200 // Forced standby limit in cycles.
)
(
  input wire logic core_clk, // Clock.
  input wire logic rst, // Reset.
  input wire logic standby_n, // Standby pin.
  input wire logic mode_fault_in, // Shared pin level.
  input wire logic supply_ok, // Supply present.
  input wire logic high_sw_1, // High switch 1.
  input wire logic high_sw_2, // High switch 2.
  input wire logic low_sw_1, // Low switch 1.
  input wire logic low_sw_2, // Low switch 2.
  input wire logic fault_pin_out, // Pin output level.
  input wire logic fault_pin_oe, // Pull-down enable.
  input wire logic phase_mode, // Latched mode.
  input wire logic standby_active // In standby.
);
  // Limits with room for the synchronisers and the dead time.
  localparam int SLEEP_LIM = SLEEP_MAX + 12;
  localparam int HIZ_AT = OC_DIS + 16;
  // Cycles since the fault flag rose.
  logic [23:0] age_reg;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (rst);
  // The fault age restarts whenever the flag is off.
  always_ff @(posedge core_clk)
  begin
    if (rst || !fault_pin_oe)
      age_reg <= 24'h000000;
    else
      age_reg <= age_reg + 24'h000001;
  end
  chk_no_shoot: assert property (!(high_sw_1 && low_sw_1) && !(high_sw_2 && low_sw_2))
    else $error("Both switches of one leg are on.");
  chk_dead_leg1: assert property ($fell(high_sw_1) |-> !low_sw_1 [*5])
    else $error("Low switch 1 came on within the dead time.");
  chk_dead_leg2: assert property ($rose(high_sw_2) |-> !$past(low_sw_2) && !$past(low_sw_2, 5))
    else $error("High switch 2 came on within the dead time.");
  chk_pin_low: assert property (fault_pin_oe |-> !fault_pin_out)
    else $error("Shared pin not pulled low in a fault.");
  chk_standby_off: assert property (standby_active && $past(standby_active, 2)
    |-> !(high_sw_1 || high_sw_2 || low_sw_1 || low_sw_2))
    else $error("A switch is on in standby.");
  chk_standby_clear: assert property (standby_active && $past(standby_active) |-> !fault_pin_oe)
    else $error("Fault flag kept in standby.");
  chk_fault_clear: assert property ($fell(fault_pin_oe) |-> standby_active
    || !$past(supply_ok, 3) || !$past(supply_ok, 4) || !$past(supply_ok, 5))
    else $error("Fault flag cleared without standby or supply loss.");
  chk_release_run: assert property ($rose(standby_n) ##1 standby_n [*4] |-> !standby_active)
    else $error("Standby not left after release.");
  chk_standby_force: assert property ($fell(standby_n) && !standby_active
    |-> ##[1:SLEEP_LIM] standby_active)
    else $error("Standby not forced in time.");
  chk_fault_hiz: assert property (age_reg == HIZ_AT
    |-> !(high_sw_1 || high_sw_2 || low_sw_1 || low_sw_2))
    else $error("Outputs not off after fault discharge.");
  chk_mode_latch: assert property ($fell(standby_active) |-> phase_mode == $past(mode_fault_in, 3))
    else $error("Mode not taken from the shared pin.");
endmodule
bind hbridge_fault_standby_control hbridge_fault_standby_control_assertions
  #(.OC_DIS(OC_DIS), .SLEEP_MAX(SLEEP_MAX)) i_chk (.core_clk(core_clk), .rst(rst),
  .standby_n(standby_n), .mode_fault_in(mode_fault_in), .supply_ok(supply_ok),
  .high_sw_1(high_sw_1), .high_sw_2(high_sw_2), .low_sw_1(low_sw_1), .low_sw_2(low_sw_2),
  .fault_pin_out(fault_pin_out), .fault_pin_oe(fault_pin_oe), .phase_mode(phase_mode),
  .standby_active(standby_active));
`default_nettype wire

/* File: tb/hbridge_fault_standby_control_tb.sv */
// Self-checking testbench of the H-bridge control block.
`timescale 1ns/1ns
`default_nettype none
module hbridge_fault_standby_control_tb;
  localparam int SZ_T = 50; // Standby delay after zero current.
  localparam int SM_T = 200; // Forced standby limit.
  logic core_clk = 1'b0; // Clock.
  logic rst = 1'b1; // Reset.
  logic standby_n = 1'b0; // Standby pin.
  logic in1 = 1'b0; // Input 1.
  logic in2 = 1'b0; // Input 2.
  logic supply_ok = 1'b1; // Supply present.
  logic thermal_trip = 1'b0; // Thermal comparator.
  logic overcurrent_trip = 1'b0; // Over-current comparator.
  logic oc_on_high = 1'b0; // Over-current side.
  logic limit_hit = 1'b0; // Current threshold reached.
  logic current_zero = 1'b0; // Zero current.
  logic drive_en = 1'b0; // Host drives the shared pin.
  logic drive_level = 1'b0; // Host level on the shared pin.
  wire logic mode_fault_in; // Shared pin level.
  wire logic high_sw_1, high_sw_2, low_sw_1, low_sw_2; // Switches.
  wire logic fault_pin_out, fault_pin_oe, phase_mode, standby_active; // Status.
  wire logic [3:0] sw; // Switches as one nibble.
  int fail_count = 0; // Mismatches.
  int comparisons = 0; // Comparisons made.
  assign sw = {high_sw_1, high_sw_2, low_sw_1, low_sw_2};
  // The clock toggles every 10 ns, half of its 20 ns period.
  always #10 core_clk = ~core_clk;
  hbridge_fault_standby_control #(.HEAT_MAX(200), .OC_DIS(300), .SLEEP_ZERO(SZ_T),
    .SLEEP_MAX(SM_T)) i_dut (.core_clk(core_clk), .rst(rst), .clk_en(1'b1),
    .standby_n(standby_n), .mode_fault_in(mode_fault_in), .in1(in1), .in2(in2),
    .supply_ok(supply_ok), .thermal_trip(thermal_trip), .overcurrent_trip(overcurrent_trip),
    .oc_on_high(oc_on_high), .limit_hit(limit_hit), .current_zero(current_zero),
    .high_sw_1(high_sw_1), .high_sw_2(high_sw_2), .low_sw_1(low_sw_1), .low_sw_2(low_sw_2),
    .fault_pin_out(fault_pin_out), .fault_pin_oe(fault_pin_oe), .phase_mode(phase_mode),
    .standby_active(standby_active));
  host_pin_model i_host (.fault_pin_oe(fault_pin_oe), .fault_pin_out(fault_pin_out),
    .drive_en(drive_en), .drive_level(drive_level), .pin_level(mode_fault_in));
  // Waits for edges, then steps just past the last one.
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask
  // Compares a seen value with the expected one.
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Prints the verdict and ends the run.
  task automatic conclude();
    if (fail_count == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Releases standby with a mode level held around the edge, then lets go of the pin.
  task automatic wake(input logic mode);
    drive_level = mode;
    drive_en = 1'b1;
    tick(4);
    standby_n = 1'b1;
    tick(12);
    drive_en = 1'b0;
    check(phase_mode, mode);
    check(standby_active, 1'b0);
  endtask
  // Applies an input pair and checks the settled switch set.
  task automatic drive(input logic a, input logic b, input logic [3:0] exp);
    in1 = a;
    in2 = b;
    tick(16);
    check(sw, exp);
  endtask
  // Raises the threshold hit to reach slow decay, then drops it and checks the return to charge.
  task automatic chop(input logic [3:0] chg);
    int slow_seen;
    slow_seen = 0;
    limit_hit = 1'b1;
    repeat (64)
    begin
      tick(1);
      if (sw === 4'h3)
        slow_seen++;
    end
    check(slow_seen > 0, 1'b1);
    limit_hit = 1'b0;
    tick(40);
    check(sw, chg);
  endtask
  // Requests standby and checks the time it takes.
  task automatic sleep(input logic zero, input int lo, input int hi);
    int n;
    n = 0;
    current_zero = zero;
    standby_n = 1'b0;
    while (standby_active !== 1'b1 && n < 400)
    begin
      tick(1);
      n++;
    end
    check(n >= lo && n <= hi, 1'b1);
    tick(2);
    check(fault_pin_oe, 1'b0);
    check(phase_mode, 1'b0);
    current_zero = 1'b0;
  endtask
  // Raises an over-current long enough to pass the dead band.
  task automatic overcurrent(input logic high_side, input logic [3:0] exp);
    oc_on_high = high_side;
    overcurrent_trip = 1'b1;
    tick(80);
    overcurrent_trip = 1'b0;
    tick(4);
    check(fault_pin_oe, 1'b1);
    check(sw, exp);
  endtask
  // Loses the supply briefly and checks the flag clears.
  task automatic supply_cycle();
    supply_ok = 1'b0;
    tick(4);
    supply_ok = 1'b1;
    tick(8);
    check(fault_pin_oe, 1'b0);
    check(mode_fault_in, 1'b1);
  endtask
  // Main sequence.
  initial
  begin
    tick(10);
    rst = 1'b0;
    tick(2);
    check(standby_active, 1'b1);
    check(sw, 4'h0);
    wake(1'b0);
    drive(1'b1, 1'b0, 4'h9);
    chop(4'h9);
    drive(1'b0, 1'b1, 4'h6);
    drive(1'b1, 1'b1, 4'h3);
    drive(1'b0, 1'b0, 4'h0);
    overcurrent_trip = 1'b1;
    tick(40);
    overcurrent_trip = 1'b0;
    tick(8);
    check(fault_pin_oe, 1'b0);
    drive(1'b1, 1'b0, 4'h9);
    thermal_trip = 1'b1;
    tick(4);
    thermal_trip = 1'b0;
    tick(16);
    check(sw, 4'h6);
    check(mode_fault_in, 1'b0);
    tick(200);
    check(sw, 4'h0);
    check(fault_pin_oe, 1'b1);
    supply_cycle();
    sleep(1'b1, SZ_T, SZ_T + 10);
    wake(1'b1);
    drive(1'b1, 1'b1, 4'h9);
    drive(1'b0, 1'b1, 4'h6);
    drive(1'b1, 1'b0, 4'h0);
    drive(1'b1, 1'b1, 4'h9);
    overcurrent(1'b1, 4'h3);
    tick(300);
    check(sw, 4'h0);
    sleep(1'b0, SM_T, SM_T + 10);
    wake(1'b0);
    drive(1'b0, 1'b1, 4'h6);
    overcurrent(1'b0, 4'hC);
    supply_cycle();
    conclude();
  end
  // Cuts a hang short.
  initial
  begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    conclude();
  end
endmodule
`default_nettype wire

/* File: tb/host_pin_model.sv */
// Host side of the shared mode and fault pin, with its pull-up.
`timescale 1ns/1ns
`default_nettype none
module host_pin_model
(
  input wire logic fault_pin_oe, // Device pull-down enable.
  input wire logic fault_pin_out, // Device drive level.
  input wire logic drive_en, // Host drives the pin.
  input wire logic drive_level, // Host drive level.
  output logic pin_level // Resolved pin level.
);
  // The device pull-down wins; else the host level; else the pull-up.
  assign pin_level = fault_pin_oe ? fault_pin_out : (drive_en ? drive_level : 1'b1);
endmodule
`default_nettype wire
